// ===== csm_top.sv
`timescale 1ns/1ps
module csm_top
   import csm_pkg::*;
#(
   parameter bit CAL_BYPASS = 1'b0,
   parameter int TICK_CYCLES = TICK_CYC,
   parameter int DELAY_MS = RUN_DELAY_MS,
   parameter int CHECK_WORDS = CHK_WORDS
)
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic pass_switch_high_i,
   input wire logic pass_switch_low_i,
   output logic cal_auto_en_o,
   output logic [3:0] cal_auto_sel_o,
   output logic cal_err_o,
   output logic pass_start_o,
   output csm_pass_type pass_kind_o,
   input wire logic pass_done_i,
   output csm_mem_req_type mem_o,
   input wire logic mem_ack_i,
   input wire logic [MEM_DW-1:0] mem_rdata_i,
   output logic checker_active_lamp_o,
   output logic mismatch_lamp_o,
   output logic pass_lamp_o,
   output logic running_lamp_o,
   input wire logic [REG_AW-1:0] reg_addr_i,
   input wire logic [REG_DW-1:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [REG_DW-1:0] reg_rdata_o,
   output logic irq_o
);

   // Refuse values the counters cannot serve
   if (TICK_CYCLES < 1 || DELAY_MS < 1 || CHECK_WORDS < 1 || CHECK_WORDS > (1 << MEM_AW))
   begin
      $error("csm_top: unusable parameter value");
   end

   typedef enum logic [2:0] {ST_WAIT, ST_CAL, ST_WRITE, ST_READ, ST_PASS, ST_FAIL,
      ST_CALERR} csm_state_type;

   function automatic logic [3:0] sel_from_switch(input logic [1:0] sw);
      case (sw)
         2'h0: return SEL_ALL;
         2'h1: return SEL_GATE;
         2'h2: return SEL_READ;
         default: return SEL_WRITE;
      endcase
   endfunction

   function automatic logic [MEM_DW-1:0] pattern(input logic [MEM_AW-1:0] a);
      return {~a, a};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Switch synchronisers
   logic [2:0] sw_hi_sync_reg;
   logic [2:0] sw_lo_sync_reg;
   logic [1:0] sw_stable_reg;

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         sw_hi_sync_reg <= 3'h0;
         sw_lo_sync_reg <= 3'h0;
         sw_stable_reg <= 2'h0;
      end
      else
      begin
         sw_hi_sync_reg <= {sw_hi_sync_reg[1:0], pass_switch_high_i};
         sw_lo_sync_reg <= {sw_lo_sync_reg[1:0], pass_switch_low_i};
         if (sw_hi_sync_reg[1] == sw_hi_sync_reg[2])
            sw_stable_reg[1] <= sw_hi_sync_reg[2];
         if (sw_lo_sync_reg[1] == sw_lo_sync_reg[2])
            sw_stable_reg[0] <= sw_lo_sync_reg[2];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Start-up delay: millisecond enable and counter
   csm_state_type state_reg;
   logic [31:0] tick_cnt_reg;
   logic [31:0] ms_cnt_reg;
   wire ms_tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
   wire delay_done = ms_tick && (ms_cnt_reg == 32'(DELAY_MS - 1));

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i || state_reg != ST_WAIT)
      begin
         tick_cnt_reg <= 32'h0;
         ms_cnt_reg <= 32'h0;
      end
      else if (ms_tick)
      begin
         tick_cnt_reg <= 32'h0;
         ms_cnt_reg <= ms_cnt_reg + 32'h1;
      end
      else
         tick_cnt_reg <= tick_cnt_reg + 32'h1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Calibration pass sequencer
   logic auto_en_reg;
   logic [3:0] sel_reg;
   logic seq_done;
   logic seq_err;

   csm_cal_seq u_seq (
      .sys_clk_i(sys_clk_i),
      .srst_i(srst_i),
      .start_i(auto_en_reg),
      .sel_i(sel_reg),
      .pass_done_i(pass_done_i),
      .pass_start_o(pass_start_o),
      .pass_kind_o(pass_kind_o),
      .done_o(seq_done),
      .err_o(seq_err)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence and memory checker
   csm_lamp_type lamp_reg;
   logic [MEM_AW-1:0] idx_reg;
   logic [MEM_DW-1:0] wdata_reg;
   logic cal_err_reg;
   wire last_word = (idx_reg == MEM_AW'(CHECK_WORDS - 1));
   wire xfer = mem_o.req && mem_ack_i;
   wire rd_bad = (state_reg == ST_READ) && mem_ack_i && (mem_rdata_i != pattern(idx_reg));
   wire [MEM_AW-1:0] idx_inc = last_word ? MEM_AW'(0) : idx_reg + MEM_AW'(1);

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         state_reg <= ST_WAIT;
         lamp_reg <= '0;
         auto_en_reg <= 1'b0;
         sel_reg <= 4'h0;
         idx_reg <= '0;
         wdata_reg <= pattern('0);
         cal_err_reg <= 1'b0;
      end
      else
      begin
         auto_en_reg <= 1'b0;
         if (xfer)
         begin
            idx_reg <= idx_inc;
            wdata_reg <= pattern(idx_inc);
         end
         case (state_reg)
            ST_WAIT:
               if (delay_done)
               begin
                  lamp_reg.running <= 1'b1;
                  if (CAL_BYPASS)
                  begin
                     lamp_reg.active <= 1'b1;
                     state_reg <= ST_WRITE;
                  end
                  else
                  begin
                     sel_reg <= sel_from_switch(sw_stable_reg);
                     auto_en_reg <= 1'b1;
                     state_reg <= ST_CAL;
                  end
               end
            ST_CAL:
               if (seq_err)
               begin
                  cal_err_reg <= 1'b1;
                  state_reg <= ST_CALERR;
               end
               else if (seq_done)
               begin
                  lamp_reg.active <= 1'b1;
                  state_reg <= ST_WRITE;
               end
            ST_WRITE:
               if (xfer && last_word)
                  state_reg <= ST_READ;
            ST_READ:
               if (rd_bad)
               begin
                  lamp_reg.mismatch <= 1'b1;
                  lamp_reg.active <= 1'b0;
                  state_reg <= ST_FAIL;
               end
               else if (xfer && last_word)
               begin
                  lamp_reg.pass <= 1'b1;
                  state_reg <= ST_PASS;
               end
            ST_PASS, ST_FAIL, ST_CALERR: state_reg <= state_reg;
            default: state_reg <= ST_WAIT;
         endcase
      end
   end

   assign mem_o.req = (state_reg == ST_WRITE) || (state_reg == ST_READ);
   assign mem_o.we = (state_reg == ST_WRITE);
   assign mem_o.addr = idx_reg;
   assign mem_o.wdata = wdata_reg;
   assign cal_auto_en_o = auto_en_reg;
   assign cal_auto_sel_o = sel_reg;
   assign cal_err_o = cal_err_reg;
   assign checker_active_lamp_o = lamp_reg.active;
   assign mismatch_lamp_o = lamp_reg.mismatch;
   assign pass_lamp_o = lamp_reg.pass;
   assign running_lamp_o = lamp_reg.running;

   ////////////////////////////////////////////////////////////////////////////
   // Register port and interrupt
   logic [IRQ_W-1:0] irq_stat_reg;
   logic [IRQ_W-1:0] irq_en_reg;
   logic [REG_DW-1:0] rdata_reg;
   wire [IRQ_W-1:0] irq_event = {seq_err, rd_bad, (state_reg == ST_READ) && !rd_bad
      && xfer && last_word};
   wire wr_clr = reg_wr_i && (reg_addr_i == ADDR_IRQ_CLR);
   wire wr_en = reg_wr_i && (reg_addr_i == ADDR_IRQ_EN);
   wire [IRQ_W-1:0] irq_stat_next = (irq_stat_reg & ~(wr_clr ? reg_wdata_i[IRQ_W-1:0]
      : '0)) | irq_event;
   wire [REG_DW-1:0] status_word = REG_DW'({CAL_BYPASS, sel_reg, lamp_reg.running,
      lamp_reg.pass, lamp_reg.mismatch, lamp_reg.active});
   wire [REG_DW-1:0] rd_mux = (reg_addr_i == ADDR_STATUS) ? status_word :
      (reg_addr_i == ADDR_IRQ_STAT) ? REG_DW'(irq_stat_reg) :
      (reg_addr_i == ADDR_IRQ_EN) ? REG_DW'(irq_en_reg) : '0;

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         irq_stat_reg <= '0;
         irq_en_reg <= IRQ_EN_RST;
         rdata_reg <= '0;
      end
      else
      begin
         irq_stat_reg <= irq_stat_next;
         if (wr_en)
            irq_en_reg <= reg_wdata_i[IRQ_W-1:0];
         rdata_reg <= reg_rd_i ? rd_mux : '0;
      end
   end

   assign reg_rdata_o = rdata_reg;
   assign irq_o = |(irq_stat_reg & irq_en_reg);

   ////////////////////////////////////////////////////////////////////////////
   a_sel_switch: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      cal_auto_en_o && $past(sw_stable_reg) == 2'h3 |-> cal_auto_sel_o == 4'h4)
      else $error("both switches high must select write leveling only");
   a_sel_encode: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      cal_auto_en_o |-> cal_auto_sel_o == sel_from_switch($past(sw_stable_reg)))
      else $error("select code does not match switches");
   a_bypass_skip: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      CAL_BYPASS |-> !cal_auto_en_o && state_reg != ST_CAL)
      else $error("calibration started in bypass mode");
   a_run_delay: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $rose(running_lamp_o) |-> $past(ms_cnt_reg) == 32'(DELAY_MS - 1) && $past(ms_tick))
      else $error("running lamp lit before the start-up delay");
   a_cal_start: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $rose(running_lamp_o) |-> cal_auto_en_o == !CAL_BYPASS
         && (CAL_BYPASS ? state_reg == ST_WRITE : state_reg == ST_CAL))
      else $error("wrong step after running lamp");
   a_active_on: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      mem_o.req |-> checker_active_lamp_o && running_lamp_o)
      else $error("checker runs without active lamp");
   a_pass_lamp: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      $rose(pass_lamp_o) |-> $past(state_reg) == ST_READ && $past(xfer)
         && !$past(rd_bad) && !mismatch_lamp_o)
      else $error("pass lamp without clean read-back");
   a_mismatch_lamp: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      rd_bad |=> mismatch_lamp_o && !pass_lamp_o ##1 mismatch_lamp_o)
      else $error("mismatch not reported");
   a_active_off: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      rd_bad |=> !checker_active_lamp_o && !mem_o.req)
      else $error("active lamp stayed on after mismatch");

endmodule

// ===== csm_pkg.sv
package csm_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Timing
   localparam int CLK_HZ = 50_000_000;
   localparam int RUN_DELAY_S = 3;
   localparam int MS_PER_S = 1000;
   localparam int TICK_CYC = CLK_HZ / MS_PER_S;
   localparam int RUN_DELAY_MS = RUN_DELAY_S * MS_PER_S;

   ////////////////////////////////////////////////////////////////////////////
   // Calibration select codes and bit positions
   localparam logic [3:0] SEL_ALL = 4'h7;
   localparam logic [3:0] SEL_GATE = 4'h2;
   localparam logic [3:0] SEL_READ = 4'h1;
   localparam logic [3:0] SEL_WRITE = 4'h4;
   localparam int SEL_WL_BIT = 2;
   localparam int SEL_GT_BIT = 1;
   localparam int SEL_RL_BIT = 0;
   localparam int SEL_RSV_BIT = 3;

   ////////////////////////////////////////////////////////////////////////////
   // Register map
   localparam int REG_AW = 8;
   localparam int REG_DW = 32;
   localparam logic [7:0] ADDR_STATUS = 8'h00;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_CLR = 8'h08;
   localparam logic [7:0] ADDR_IRQ_EN = 8'h0c;
   localparam logic [2:0] IRQ_EN_RST = 3'h0;
   localparam int IRQ_W = 3;
   localparam int IRQ_PASS = 0;
   localparam int IRQ_FAIL = 1;
   localparam int IRQ_CALERR = 2;
   localparam int STAT_LAMP_LSB = 0;
   localparam int STAT_SEL_LSB = 4;
   localparam int STAT_BYPASS_BIT = 8;

   ////////////////////////////////////////////////////////////////////////////
   // Memory port
   localparam int MEM_AW = 16;
   localparam int MEM_DW = 32;
   localparam int CHK_WORDS = 256;

   typedef struct packed
   {
      logic req;
      logic we;
      logic [MEM_AW-1:0] addr;
      logic [MEM_DW-1:0] wdata;
   } csm_mem_req_type;

   typedef struct packed
   {
      logic running;
      logic pass;
      logic mismatch;
      logic active;
   } csm_lamp_type;

   typedef enum logic [1:0] {PASS_WL, PASS_GT, PASS_RL} csm_pass_type;

endpackage

// ===== csm_cal_seq.sv
`timescale 1ns/1ps
module csm_cal_seq
   import csm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic start_i,
   input wire logic [3:0] sel_i,
   input wire logic pass_done_i,
   output logic pass_start_o,
   output csm_pass_type pass_kind_o,
   output logic done_o,
   output logic err_o
);

   typedef enum logic [1:0] {SQ_IDLE, SQ_ISSUE, SQ_WAIT} csm_sq_type;

   function automatic csm_pass_type next_kind(input logic [2:0] pend);
      if (pend[SEL_WL_BIT])
         return PASS_WL;
      else if (pend[SEL_GT_BIT])
         return PASS_GT;
      else
         return PASS_RL;
   endfunction

   function automatic logic [2:0] kind_mask(input csm_pass_type k);
      case (k)
         PASS_WL: return 3'h4;
         PASS_GT: return 3'h2;
         default: return 3'h1;
      endcase
   endfunction

   csm_sq_type st_reg;
   logic [2:0] pend_reg;
   csm_pass_type kind_reg;
   logic start_reg;
   logic done_reg;
   logic err_reg;
   wire sel_bad = sel_i[SEL_RSV_BIT] || (sel_i[2:0] == 3'h0);

   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         st_reg <= SQ_IDLE;
         pend_reg <= 3'h0;
         kind_reg <= PASS_WL;
         start_reg <= 1'b0;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
      end
      else
      begin
         start_reg <= 1'b0;
         done_reg <= 1'b0;
         err_reg <= 1'b0;
         case (st_reg)
            SQ_IDLE:
               if (start_i)
               begin
                  if (sel_bad)
                     err_reg <= 1'b1;
                  else
                  begin
                     pend_reg <= sel_i[2:0];
                     st_reg <= SQ_ISSUE;
                  end
               end
            SQ_ISSUE:
               if (pend_reg == 3'h0)
               begin
                  done_reg <= 1'b1;
                  st_reg <= SQ_IDLE;
               end
               else
               begin
                  kind_reg <= next_kind(pend_reg);
                  start_reg <= 1'b1;
                  st_reg <= SQ_WAIT;
               end
            SQ_WAIT:
               if (pass_done_i)
               begin
                  pend_reg <= pend_reg & ~kind_mask(kind_reg);
                  st_reg <= SQ_ISSUE;
               end
            default: st_reg <= SQ_IDLE;
         endcase
      end
   end

   assign pass_start_o = start_reg;
   assign pass_kind_o = kind_reg;
   assign done_o = done_reg;
   assign err_o = err_reg;

   ////////////////////////////////////////////////////////////////////////////
   a_seq_start: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      start_i && !sel_bad && st_reg == SQ_IDLE |-> ##2 pass_start_o)
      else $error("valid start did not launch a pass");
   a_pass_order: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      pass_start_o && pass_kind_o != PASS_WL |-> !pend_reg[SEL_WL_BIT]
         && (pass_kind_o == PASS_GT || !pend_reg[SEL_GT_BIT]))
      else $error("calibration pass issued out of order");
   a_bad_sel: assert property (@(posedge sys_clk_i) disable iff (srst_i)
      start_i && sel_bad && st_reg == SQ_IDLE |=> err_o && !pass_start_o)
      else $error("invalid select did not raise error");

endmodule

// ===== csm_far_model.sv
`timescale 1ns/1ps
module csm_far_model
   import csm_pkg::*;
(
   input wire logic sys_clk_i,
   input wire logic srst_i,
   input wire logic slow_i,
   input wire logic corrupt_i,
   input wire logic pass_start_i,
   output logic pass_done_o,
   input wire csm_mem_req_type mem_i,
   output logic mem_ack_o,
   output logic [MEM_DW-1:0] mem_rdata_o
);
   logic [3:0] wait_reg;
   logic busy_reg;
   logic phase_reg;
   logic [MEM_DW-1:0] last_reg;
   logic [MEM_DW-1:0] store_reg [0:15];
   logic [MEM_DW-1:0] word;

   ////////////////////////////////////////////////////////////////////////////
   // Memory side: slow mode accepts every other cycle
   assign mem_ack_o = mem_i.req && (!slow_i || phase_reg);
   assign word = store_reg[mem_i.addr[3:0]] ^ {{(MEM_DW-1){1'b0}}, corrupt_i};
   // Outside a read accept the bus shows garbage, not the last word
   assign mem_rdata_o = (mem_ack_o && !mem_i.we) ? word : ~last_reg;

   ////////////////////////////////////////////////////////////////////////////
   // Calibration side: one done pulse per started pass
   always_ff @(posedge sys_clk_i)
   begin
      if (srst_i)
      begin
         busy_reg <= 1'b0;
         pass_done_o <= 1'b0;
         phase_reg <= 1'b0;
         last_reg <= '0;
         wait_reg <= 4'h0;
      end
      else
      begin
         phase_reg <= ~phase_reg;
         pass_done_o <= 1'b0;
         if (pass_start_i)
         begin
            busy_reg <= 1'b1;
            wait_reg <= slow_i ? 4'h6 : 4'h1;
         end
         else if (busy_reg && wait_reg == 4'h0)
         begin
            pass_done_o <= 1'b1;
            busy_reg <= 1'b0;
         end
         else if (busy_reg)
            wait_reg <= wait_reg - 4'h1;
         if (mem_ack_o && mem_i.we)
            store_reg[mem_i.addr[3:0]] <= mem_i.wdata;
         if (mem_ack_o)
            last_reg <= mem_rdata_o;
      end
   end
endmodule

// ===== test_calibration_select_and_memcheck_status.sv
`timescale 1ns/1ps
`define CHECK(what, expv, gotv) begin total_checks++; if ((gotv) !== (expv)) begin n_fail++; \
   $display("ERROR %s expected %h seen %h", what, expv, gotv); end end
module test_calibration_select_and_memcheck_status
   import csm_pkg::*;
;
   logic sys_clk_i, srst_i, sw_hi, sw_lo, slow_r, corrupt_r, reg_wr, reg_rd;
   logic [7:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic en, err, pstart, pdone, ack, irq, act, mis, pas, run;
   logic [3:0] sel;
   csm_pass_type kind;
   csm_mem_req_type mem;
   logic [MEM_DW-1:0] rdata;
   logic b_en, b_pstart, b_pdone, b_ack, b_act, b_pas, b_run, b_err, b_mis, b_irq;
   logic [31:0] b_rd;
   csm_mem_req_type b_mem;
   logic [MEM_DW-1:0] b_rdata;
   int n_fail, total_checks;

   csm_top #(.CAL_BYPASS(1'b0), .TICK_CYCLES(4), .DELAY_MS(3), .CHECK_WORDS(4)) dut (
      .sys_clk_i(sys_clk_i), .srst_i(srst_i), .pass_switch_high_i(sw_hi),
      .pass_switch_low_i(sw_lo), .cal_auto_en_o(en), .cal_auto_sel_o(sel), .cal_err_o(err),
      .pass_start_o(pstart), .pass_kind_o(kind), .pass_done_i(pdone), .mem_o(mem),
      .mem_ack_i(ack), .mem_rdata_i(rdata), .checker_active_lamp_o(act),
      .mismatch_lamp_o(mis), .pass_lamp_o(pas), .running_lamp_o(run),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(reg_rdata), .irq_o(irq));
   csm_far_model far (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .slow_i(slow_r),
      .corrupt_i(corrupt_r), .pass_start_i(pstart), .pass_done_o(pdone), .mem_i(mem),
      .mem_ack_o(ack), .mem_rdata_o(rdata));
   csm_top #(.CAL_BYPASS(1'b1), .TICK_CYCLES(4), .DELAY_MS(3), .CHECK_WORDS(4)) dut_byp (
      .sys_clk_i(sys_clk_i), .srst_i(srst_i), .pass_switch_high_i(sw_hi),
      .pass_switch_low_i(sw_lo), .cal_auto_en_o(b_en), .cal_auto_sel_o(), .cal_err_o(b_err),
      .pass_start_o(b_pstart), .pass_kind_o(), .pass_done_i(b_pdone), .mem_o(b_mem),
      .mem_ack_i(b_ack), .mem_rdata_i(b_rdata), .checker_active_lamp_o(b_act),
      .mismatch_lamp_o(b_mis), .pass_lamp_o(b_pas), .running_lamp_o(b_run),
      .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
      .reg_rdata_o(b_rd), .irq_o(b_irq));
   csm_far_model far_byp (.sys_clk_i(sys_clk_i), .srst_i(srst_i), .slow_i(slow_r),
      .corrupt_i(corrupt_r), .pass_start_i(b_pstart), .pass_done_o(b_pdone), .mem_i(b_mem),
      .mem_ack_o(b_ack), .mem_rdata_o(b_rdata));

   initial
   begin
      sys_clk_i = 1'b0;
      forever #10 sys_clk_i = ~sys_clk_i;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared tasks
   task results();
      if (n_fail == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task timeout(input string what);
      n_fail++;
      $display("ERROR %s expected done seen timeout", what);
      results();
   endtask

   task do_reset(input int n);
      @(posedge sys_clk_i);
      srst_i <= 1'b1;
      repeat (n) @(posedge sys_clk_i);
      srst_i <= 1'b0;
   endtask

   task reg_write(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk_i);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk_i);
      reg_wr <= 1'b0;
      #1;
   endtask

   task reg_read(input logic [7:0] a, output logic [31:0] d);
      @(posedge sys_clk_i);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk_i);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task run_flow(input logic [1:0] sw, input logic slow, input logic corrupt);
      int n;
      int i;
      logic [3:0] code;
      csm_pass_type got_q[$];
      csm_pass_type exp_q[$];
      code = (sw == 2'b00) ? SEL_ALL : (sw == 2'b01) ? SEL_GATE :
             (sw == 2'b10) ? SEL_READ : SEL_WRITE;
      if (code[SEL_WL_BIT]) exp_q.push_back(PASS_WL);
      if (code[SEL_GT_BIT]) exp_q.push_back(PASS_GT);
      if (code[SEL_RL_BIT]) exp_q.push_back(PASS_RL);
      sw_hi <= sw[1];
      sw_lo <= sw[0];
      slow_r <= slow;
      corrupt_r <= corrupt;
      do_reset(4);
      n = 0;
      while (run !== 1'b1)
      begin
         if (n > 60) timeout("running_lamp");
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      `CHECK("run_delay", 1'b1, (n >= 11 && n <= 14))
      `CHECK("auto_en", 1'b1, en)
      `CHECK("active_early", 1'b0, act)
      @(posedge sys_clk_i);
      #1;
      `CHECK("select_code", code, sel)
      n = 0;
      while (act !== 1'b1)
      begin
         if (pstart === 1'b1) got_q.push_back(kind);
         if (n > 300) timeout("active_lamp");
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      `CHECK("pass_count", exp_q.size(), got_q.size())
      for (i = 0; i < exp_q.size() && i < got_q.size(); i++)
         `CHECK("pass_order", exp_q[i], got_q[i])
      n = 0;
      while (pas !== 1'b1 && mis !== 1'b1)
      begin
         if (n > 100) timeout("check_result");
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      `CHECK("pass_lamp", !corrupt, pas)
      `CHECK("mismatch_lamp", corrupt, mis)
      if (corrupt) `CHECK("active_off", 1'b0, act)
      `CHECK("cal_err", 1'b0, err)
   endtask

   task reg_check();
      logic [31:0] d;
      reg_read(ADDR_IRQ_STAT, d);
      `CHECK("irq_stat", 32'h0000_0002, d)
      `CHECK("irq_masked", 1'b0, irq)
      reg_write(ADDR_IRQ_STAT, 32'h0000_0000);
      reg_write(ADDR_IRQ_EN, 32'h0000_0007);
      `CHECK("irq_on", 1'b1, irq)
      reg_read(ADDR_IRQ_EN, d);
      `CHECK("irq_en", 32'h0000_0007, d)
      reg_write(ADDR_IRQ_CLR, 32'h0000_0002);
      `CHECK("irq_off", 1'b0, irq)
      reg_read(ADDR_IRQ_STAT, d);
      `CHECK("irq_cleared", 32'h0000_0000, d)
      reg_read(ADDR_STATUS, d);
      `CHECK("status_sel", 5'h04, d[8:4])
      `CHECK("status_lamps", 4'ha, d[3:0])
      reg_read(8'h10, d);
      `CHECK("unmapped", 32'h0000_0000, d)
      reg_read(ADDR_IRQ_CLR, d);
      `CHECK("clear_reads_zero", 32'h0000_0000, d)
   endtask

   task run_bypass();
      int n;
      int starts;
      logic [31:0] d;
      starts = 0;
      slow_r <= 1'b1;
      corrupt_r <= 1'b0;
      do_reset(4);
      n = 0;
      while (b_pas !== 1'b1)
      begin
         if (b_en === 1'b1) starts++;
         if (b_run === 1'b1 && n >= 0)
         begin
            `CHECK("byp_active", 1'b1, b_act)
            n = -1000;
         end
         if (n > 200) timeout("bypass_pass");
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      `CHECK("byp_no_cal", 0, starts)
      `CHECK("byp_pass", 1'b1, b_pas)
      `CHECK("byp_mis", 1'b0, b_mis)
      `CHECK("byp_cal_err", 1'b0, b_err)
      reg_read(ADDR_IRQ_STAT, d);
      `CHECK("byp_irq_stat", 32'h0000_0001, b_rd)
      reg_read(ADDR_STATUS, d);
      `CHECK("byp_status", 9'h10d, b_rd[8:0])
      `CHECK("byp_irq_masked", 1'b0, b_irq)
      reg_write(ADDR_IRQ_EN, 32'h0000_0001);
      `CHECK("byp_irq", 1'b1, b_irq)
   endtask

   initial
   begin
      n_fail = 0;
      total_checks = 0;
      srst_i = 1'b1;
      sw_hi = 1'b0;
      sw_lo = 1'b0;
      slow_r = 1'b0;
      corrupt_r = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0000_0000;
      repeat (12) @(posedge sys_clk_i);
      run_flow(2'b00, 1'b1, 1'b0);
      run_flow(2'b01, 1'b0, 1'b0);
      run_flow(2'b10, 1'b1, 1'b0);
      run_flow(2'b11, 1'b0, 1'b1);
      reg_check();
      run_bypass();
      results();
   end
endmodule
